// ==== verilog/aef_formatter.sv ====
// aef_formatter: sample clock tracking, duty-cycle stabilizer, code mapping and output modes
// assumes the sample clock, input level and strap pins arrive from outside clk's domain
//
// Summary of operation
// R1 - the sample clock source stays at or below 250 Msps
// R2 - without stabilizer, the source delivers 50 percent duty within five percent
// R3 - each high and low phase lasts at least 1.9 ns
// R4 - stabilizer on: sample on rising edge, internal falling edge made by a loop
// R5 - stabilizer on: 40 to 60 percent input duty still yields 50 percent internally
// R6 - after a long clock stop, one hundred edges pass before data is trusted (the code waits only with the stabilizer on)
// R7 - format pin at one third or two thirds of supply enables the stabilizer
// R8 - the source keeps the sample rate at or above 1 Msps
// R9 - 10-bit result, offset binary; two's complement inverts the top bit
// R10 - overrange flag high only beyond full scale, code then saturates
// R11 - demultiplexed modes spread samples over buses A and B at half rate
// R12 - demultiplexed buses update on alternate samples or together, as selected
// R13 - output-mode pin picks full-rate, demux simultaneous, demux interleaved or LVDS
// R14 - bus A data changes just after its clock rises, captured on the fall
// R15 - simultaneous mode: bus B changes after its clock falls; interleaved: like A
// R16 - format pin low two levels give offset binary, upper two two's complement
// R17 - single-ended buses carry own overrange flags; LVDS uses one flag
// R18 - demux samples alternate A then B, A first after the pipeline fills
// R19 - output clock toggles per sample at full rate, half rate when demultiplexed
`timescale 1ns/1ps
module aef_formatter (
  input  wire logic                             clk,
  input  wire logic                             reset,
  input  wire logic                             sampleClockPos,
  input  wire logic signed [aef_pkg::IN_W-1:0]  analogLevel,
  input  wire logic [1:0]                       outputModeLevel,
  input  wire logic [1:0]                       formatLevel,
  output logic [aef_pkg::DATA_W-1:0]            sampleCodeBitsA,
  output logic [aef_pkg::DATA_W-1:0]            sampleCodeBitsB,
  output logic                                  overrangeFlagBusA,
  output logic                                  overrangeFlagBusB,
  output logic                                  overrangeFlag,
  output logic                                  dataReadyClockBusA,
  output logic                                  dataReadyClockBusB,
  output logic                                  dataReadyClock,
  output logic                                  irq,
  input  wire logic [aef_pkg::ADDR_W-1:0]       awaddr,
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [31:0]                      wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output logic                                  wready,
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire logic                             bready,
  input  wire logic [aef_pkg::ADDR_W-1:0]       araddr,
  input  wire logic                             arvalid,
  output logic                                  arready,
  output logic [31:0]                           rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire logic                             rready
);
  import aef_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0]             encSync_r;     // [0] meta, [1] synced, [2] history
  logic signed [IN_W-1:0] levelMeta_r, level_r;
  logic [1:0]             modeMeta_r, modePin_r, fmtMeta_r, fmtPin_r;

  // two flops before use; the level bus may skew by a cycle, harmless at the bench rate
  always_ff @(posedge clk)
  begin
    if (reset)
      encSync_r <= 3'h0;
    else
      encSync_r <= {encSync_r[1:0], sampleClockPos};
    levelMeta_r <= analogLevel;
    level_r     <= levelMeta_r;
    modeMeta_r  <= outputModeLevel;
    modePin_r   <= modeMeta_r;
    fmtMeta_r   <= formatLevel;
    fmtPin_r    <= fmtMeta_r;
  end

  logic      riseEv, fallExt, stabOn, twosOn;
  aef_mode_t outMode;
  // edges of the sample clock, strap decoding
  assign riseEv  = encSync_r[1] & ~encSync_r[2];
  assign fallExt = ~encSync_r[1] & encSync_r[2];
  assign stabOn  = (fmtPin_r == 2'h1) || (fmtPin_r == 2'h2);   // [R7]
  assign twosOn  = fmtPin_r[1];                                 // [R16]
  assign outMode = aef_mode_t'(modePin_r);                      // [R13]

  // ----------------------------------------------------------------
  // period tracking and stop detection
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] sinceRise_r, period_r;
  logic             clockActive_r, stopEv;
  // a gap of STOP_CYCLES cycles, twice the slowest legal period, means the clock stopped
  assign stopEv = clockActive_r && !riseEv
                  && (sinceRise_r == CNT_W'(STOP_CYCLES - 1));  // [R8]

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sinceRise_r   <= '0;
      period_r      <= '0;
      clockActive_r <= 1'b0;
    end
    else if (riseEv)
    begin
      period_r      <= sinceRise_r + CNT_W'(1);
      sinceRise_r   <= '0;
      clockActive_r <= 1'b1;
    end
    else
    begin
      if (sinceRise_r != '1)
        sinceRise_r <= sinceRise_r + CNT_W'(1);
      if (stopEv)
        clockActive_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // duty-cycle stabilizer: lock counting and internal falling edge
  // ----------------------------------------------------------------
  logic [6:0] lockCount_r;
  logic       locked_r, lockEv, fallPt;
  assign lockEv = stabOn && riseEv && !locked_r
                  && (lockCount_r == 7'(LOCK_EDGES - 1));      // [R6]
  // with the stabilizer the external fall is ignored and the midpoint is used
  assign fallPt = stabOn ? (clockActive_r && !riseEv && (sinceRise_r == (period_r >> 1)))
                         : fallExt;                             // [R4] [R5]

  // relock restarts whenever the clock stops or the stabilizer is switched off
  always_ff @(posedge clk)
  begin
    if (reset || stopEv || !stabOn)
    begin
      lockCount_r <= 7'h0;
      locked_r    <= 1'b0;
    end
    else if (riseEv && !locked_r)
    begin
      lockCount_r <= lockCount_r + 7'h1;
      locked_r    <= lockEv;                                    // [R6]
    end
  end

  // ----------------------------------------------------------------
  // code mapping
  // ----------------------------------------------------------------
  aef_word_t word;
  logic      run_r, doSample, demux, slotB_r;
  // saturate beyond full scale, then pick the output format
  always_comb
  begin
    word.over = 1'b0;
    word.code = level_r[DATA_W-1:0];
    if (level_r > FS_POS)
    begin
      word.over = 1'b1;                                         // [R10]
      word.code = CODE_TOP;
    end
    else if (level_r < FS_NEG)
    begin
      word.over = 1'b1;                                         // [R10]
      word.code = CODE_BOT;
    end
    if (!twosOn)
      word.code[DATA_W-1] = ~word.code[DATA_W-1];               // [R9] [R16]
  end

  // outputs only move with a trusted clock and while software lets them run
  assign doSample = riseEv && run_r && (!stabOn || locked_r);   // [R4] [R6]
  assign demux    = (outMode == MODE_SIMUL) || (outMode == MODE_INTER);

  // bus A takes the first sample after reset, a switch into a demux mode, or a stabilizer relock
  always_ff @(posedge clk)
  begin
    if (reset || !demux || (stabOn && !locked_r))
      slotB_r <= 1'b0;
    else if (doSample)
      slotB_r <= ~slotB_r;                                      // [R18]
  end

  // ----------------------------------------------------------------
  // output buses and output clocks
  // ----------------------------------------------------------------
  aef_word_t hold_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sampleCodeBitsA    <= '0;
      sampleCodeBitsB    <= '0;
      overrangeFlagBusA  <= 1'b0;
      overrangeFlagBusB  <= 1'b0;
      overrangeFlag      <= 1'b0;
      dataReadyClockBusA <= 1'b0;
      dataReadyClockBusB <= 1'b0;
      dataReadyClock     <= 1'b0;
      hold_r             <= '0;
    end
    else if (doSample)
    begin
      unique case (outMode)
        MODE_FULL:
        begin
          {overrangeFlagBusA, sampleCodeBitsA} <= word;         // [R14] [R17]
          dataReadyClockBusA <= 1'b1;                           // [R19]
        end
        MODE_LVDS:
        begin
          {overrangeFlag, sampleCodeBitsA} <= word;             // [R17]
          dataReadyClock <= 1'b1;                               // [R14] [R19]
        end
        MODE_INTER:
        begin
          // each bus changes as its own clock rises, on alternate samples
          if (!slotB_r)
            {overrangeFlagBusA, sampleCodeBitsA} <= word;       // [R11] [R12]
          else
            {overrangeFlagBusB, sampleCodeBitsB} <= word;       // [R15]
          dataReadyClockBusA <= ~slotB_r;                       // [R19]
          dataReadyClockBusB <= slotB_r;
        end
        MODE_SIMUL:
        begin
          // the A sample waits one sample so both buses change together
          if (!slotB_r)
            hold_r <= word;
          else
          begin
            {overrangeFlagBusA, sampleCodeBitsA} <= hold_r;     // [R11] [R12]
            {overrangeFlagBusB, sampleCodeBitsB} <= word;       // [R15]
          end
          dataReadyClockBusA <= slotB_r;                        // [R14] [R19]
          dataReadyClockBusB <= ~slotB_r;                       // [R15]
        end
      endcase
    end
    else if (fallPt)
    begin
      // full-rate clocks fall mid-period; the receiver captures here
      if (outMode == MODE_FULL)
        dataReadyClockBusA <= 1'b0;                             // [R14]
      if (outMode == MODE_LVDS)
        dataReadyClock <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register bus: AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] wrAddr_r;
  logic [31:0]       wrData_r, sampleCount_r, rdNxt;
  logic              awHeld_r, wHeld_r, wrBe_r, commit, rdHit;
  logic [IRQ_W-1:0]  irqStat_r, irqEn_r, irqEv;
  assign commit = awHeld_r && wHeld_r && !bvalid;

  // address and data are taken in either order; the response follows both
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      wrAddr_r <= '0;
      wrData_r <= '0;
      wrBe_r   <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready  <= 1'b0;
        awHeld_r <= 1'b1;
        wrAddr_r <= awaddr;
      end
      else if (!awHeld_r && !bvalid)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        wready   <= 1'b0;
        wHeld_r  <= 1'b1;
        wrData_r <= wdata;
        wrBe_r   <= wstrb[0];
      end
      else if (!wHeld_r && !bvalid)
        wready <= 1'b1;
      if (commit)
      begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (wrAddr_r == REG_CTRL || wrAddr_r == REG_IRQ_CLEAR
                     || wrAddr_r == REG_IRQ_ENABLE) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // read mux; unmapped addresses read zero with an error response
  always_comb
  begin
    rdHit = 1'b1;
    rdNxt = '0;
    unique case (araddr)
      REG_CTRL:       rdNxt[CTRL_RUN_BIT] = run_r;
      REG_STATUS:     rdNxt[STAT_ACT_BIT:0] = {clockActive_r, locked_r, stabOn,
                                               twosOn, modePin_r};
      REG_IRQ_STATUS: rdNxt[IRQ_W-1:0] = irqStat_r;
      REG_IRQ_ENABLE: rdNxt[IRQ_W-1:0] = irqEn_r;
      REG_SAMPLES:    rdNxt = sampleCount_r;
      REG_IRQ_CLEAR:  rdNxt = '0;
      default:        rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdNxt;
      rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end

  // ----------------------------------------------------------------
  // control, counters and interrupts
  // ----------------------------------------------------------------
  assign irqEv = {stopEv, lockEv, doSample && word.over};

  // a new event wins over a clear landing in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      run_r         <= CTRL_RUN_RST;
      irqEn_r       <= '0;
      irqStat_r     <= '0;
      sampleCount_r <= '0;
      irq           <= 1'b0;
    end
    else
    begin
      if (commit && wrBe_r && wrAddr_r == REG_CTRL)
        run_r <= wrData_r[CTRL_RUN_BIT];
      if (commit && wrBe_r && wrAddr_r == REG_IRQ_ENABLE)
        irqEn_r <= wrData_r[IRQ_W-1:0];
      if (commit && wrBe_r && wrAddr_r == REG_IRQ_CLEAR)
        irqStat_r <= (irqStat_r & ~wrData_r[IRQ_W-1:0]) | irqEv;
      else
        irqStat_r <= irqStat_r | irqEv;
      if (doSample)
        sampleCount_r <= sampleCount_r + 32'h1;
      irq <= |(irqStat_r & irqEn_r);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sat_code_a: assert property (overrangeFlagBusA |-> // [R10]
      sampleCodeBitsA[DATA_W-2:0] == 9'h0 || sampleCodeBitsA[DATA_W-2:0] == 9'h1ff)
      else $error("flag without saturated code");
  fmt_map_a: assert property (doSample && outMode == MODE_FULL && !word.over |=> // [R9] [R16]
      sampleCodeBitsA == {$past(level_r[DATA_W-1]) ^ !twosOn, $past(level_r[DATA_W-2:0])}
      || $past(twosOn) != twosOn) else $error("code map wrong");
  relock_count_a: assert property ($rose(locked_r) |-> // [R6]
      $past(lockCount_r) == 7'(LOCK_EDGES - 1)) else $error("lock after wrong edge count");
  stop_unlock_a: assert property (stopEv |=> !locked_r && !clockActive_r) // [R6]
      else $error("lock kept across a stopped clock");
  unlocked_quiet_a: assert property (stabOn && !locked_r |=> // [R4] [R6]
      $stable(sampleCodeBitsA)) else $error("data moved before lock");
  a_rise_a: assert property ($changed(sampleCodeBitsA) |-> // [R14]
      $rose(dataReadyClockBusA) || $rose(dataReadyClock))
      else $error("bus A changed without clock rise");
  simul_b_a: assert property (outMode == MODE_SIMUL && $changed(sampleCodeBitsB) // [R12] [R15]
      |-> $fell(dataReadyClockBusB) && $rose(dataReadyClockBusA))
      else $error("simultaneous update out of step");
  inter_alt_a: assert property (outMode == MODE_INTER && doSample && slotB_r // [R18]
      |=> $rose(dataReadyClockBusB) && !dataReadyClockBusA) else $error("bus B slot wrong");
  // every demultiplexed sample moves the slot, so buses alternate at half rate
  demux_half_a: assert property (demux && doSample |=> slotB_r != $past(slotB_r)) // [R11]
      else $error("demux slot did not alternate");
  irq_level_a: assert property (##1 irq == $past(|(irqStat_r & irqEn_r)))
      else $error("interrupt level wrong");

  simul_cov: cover property (outMode == MODE_SIMUL && $changed(sampleCodeBitsB));
  lock_cov: cover property (lockEv);
  over_cov: cover property (doSample && word.over);
  inter_cov: cover property (outMode == MODE_INTER && $rose(dataReadyClockBusB));

endmodule

// ==== verilog/aef_pkg.sv ====
// aef_pkg: sizes, timing counts, register map and types of the encode/output formatter
// assumes a 20 MHz system clock and an AXI4-Lite register port with 32-bit data
package aef_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 10;            // output code width
  localparam int IN_W   = 12;            // digitised input level, signed, with headroom
  localparam int CNT_W  = 16;            // period and gap counters
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int STOP_TIME_NS  = 2000;   // gap that counts as a stopped sample clock
  localparam int STOP_CYCLES   = STOP_TIME_NS / CLK_PERIOD_NS;
  localparam int LOCK_EDGES    = 100;    // rising edges the stabilizer needs to relock

  // ----------------------------------------------------------------
  // code map
  // ----------------------------------------------------------------
  localparam logic signed [IN_W-1:0] FS_POS   = 12'sh1ff;
  localparam logic signed [IN_W-1:0] FS_NEG   = 12'she00;
  localparam logic [DATA_W-1:0]      CODE_TOP = 10'h1ff;  // two's complement maximum
  localparam logic [DATA_W-1:0]      CODE_BOT = 10'h200;  // two's complement minimum

  // ----------------------------------------------------------------
  // registers, byte addresses, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_SAMPLES    = 8'h14;
  localparam logic              CTRL_RUN_RST   = 1'h1;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_TWOS_BIT = 2;      // mode sits in bits 1:0
  localparam int STAT_STAB_BIT = 3;
  localparam int STAT_LOCK_BIT = 4;
  localparam int STAT_ACT_BIT  = 5;
  localparam int IRQ_W         = 3;
  localparam int IRQ_OVR_BIT   = 0;
  localparam int IRQ_LOCK_BIT  = 1;
  localparam int IRQ_STOP_BIT  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_FULL  = 2'b00,
    MODE_SIMUL = 2'b01,
    MODE_INTER = 2'b10,
    MODE_LVDS  = 2'b11
  } aef_mode_t;

  typedef struct packed {
    logic              over;
    logic [DATA_W-1:0] code;
  } aef_word_t;

endpackage

// ==== tb/aef_capture_model.sv ====
// aef_capture_model: downstream receiver that latches the formatter's output buses
// assumes registered bus outputs that hold steady between their own clock edges
`timescale 1ns/1ps
module aef_capture_model (
  input  wire logic               clkB,
  input  wire logic               clkA,
  input  wire logic               simul,
  input  wire aef_pkg::aef_word_t busA,
  input  wire aef_pkg::aef_word_t busB,
  output aef_pkg::aef_word_t      capA,
  output aef_pkg::aef_word_t      capB
);
  import aef_pkg::*;

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // bus a is taken on its clock's fall, half a period after the update
  always @(negedge clkA)
    capA <= busA;
  // bus b: rise in simultaneous style, fall in interleaved style
  always @(clkB)
    if (clkB == simul)
      capB <= busB;
endmodule

// ==== tb/test_adc_encode_and_output_formatter.sv ====
// test_adc_encode_and_output_formatter: self-checking bench for the formatter
// assumes aef_pkg, aef_formatter and the capture model are compiled before it
`timescale 1ns/1ps
module test_adc_encode_and_output_formatter;
  import aef_pkg::*;
  logic                   clk, reset, sampleClockPos, irq;
  logic signed [IN_W-1:0] analogLevel;
  logic [1:0]             outputModeLevel, formatLevel, bresp, rresp;
  logic [ADDR_W-1:0]      awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic                   awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic                   overrange_flag_bus_a, overrange_flag_bus_b, ofL, clkA, clkB, clkL;
  logic [DATA_W-1:0]      codeA, codeB;
  aef_word_t              capA, capB;
  int                     n_mismatch, checks, cyc, nRiseA, nRiseL;

  aef_formatter dut (
    .clk(clk), .reset(reset), .sampleClockPos(sampleClockPos), .analogLevel(analogLevel),
    .outputModeLevel(outputModeLevel), .formatLevel(formatLevel), .sampleCodeBitsA(codeA),
    .sampleCodeBitsB(codeB), .overrangeFlagBusA(overrange_flag_bus_a), .overrangeFlagBusB(overrange_flag_bus_b),
    .overrangeFlag(ofL), .dataReadyClockBusA(clkA), .dataReadyClockBusB(clkB),
    .dataReadyClock(clkL), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  aef_capture_model partner (
    .clkB(clkB), .clkA(clkA), .simul(outputModeLevel == MODE_SIMUL),
    .busA({overrange_flag_bus_a, codeA}), .busB({overrange_flag_bus_b, codeB}), .capA(capA), .capB(capB)
  );

  // ----------------------------------------------------------------
  // clock, timeout and output clock counters
  // ----------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // the whole run needs under 5000 cycles; a hang ends it as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude;
    end
  end
  always @(posedge clkA) nRiseA++;
  always @(posedge clkL) nRiseL++;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task conclude;
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // expected word: saturate, offset by half scale, top bit flipped for two's complement
  function automatic aef_word_t enc(input int lvl, input bit twos);
    int s;
    s = (lvl > 511) ? 511 : (lvl < -512) ? -512 : lvl;
    enc.over = (s != lvl);
    enc.code = 10'(s + 512) ^ {twos, 9'h0};
  endfunction

  task do_reset(input logic [1:0] m, input logic [1:0] f);
    @(posedge clk);
    reset <= 1;
    outputModeLevel <= m;
    formatLevel <= f;
    repeat (3) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
  endtask

  // one 400 ns sample period at its own phase: 2.5 Msps, never under 1.9 ns a phase
  task pulse(input int lvl, input int hi);
    @(posedge clk);
    analogLevel <= lvl[IN_W-1:0];
    #13 sampleClockPos = 1;
    #(hi) sampleClockPos = 0;
    #(386 - hi);
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(REG_CTRL, d, r);
    chk("ctrl run", d[CTRL_RUN_BIT], CTRL_RUN_RST);
    axr(REG_IRQ_ENABLE, d, r);
    chk("irq enable", d, 0);
    axr(8'h40, d, r);
    chk("unmapped read", r, RESP_SLVERR);
    axw(8'h40, 32'h1, r);
    chk("unmapped write", r, RESP_SLVERR);
  endtask

  task test_full;
    int        lv[5] = '{0, 511, -512, 600, -600};
    aef_word_t e;
    for (int f = 0; f < 4; f += 3)
    begin
      do_reset(MODE_FULL, f[1:0]);
      nRiseA = 0;
      foreach (lv[i])
      begin
        pulse(lv[i], 200);
        e = enc(lv[i], f == 3);
        chk("bus a code", codeA, e.code);
        chk("bus a flag", overrange_flag_bus_a, e.over);
        chk("captured a", capA, e);
      end
      chk("clock a rises", nRiseA, 5);
    end
  endtask

  task test_demux(input aef_mode_t m);
    do_reset(m, 2'd3);
    nRiseA = 0;
    pulse(100, 200);
    chk("demux b first", codeB, 0);
    pulse(-100, 200);
    chk("demux a", codeA, 10'h064);
    chk("demux b", codeB, 10'h39c);
    pulse(5, 200);
    chk("captured a", capA, 11'h064);
    chk("captured b", capB, 11'h39c);
    pulse(6, 200);
    chk("clock a rises", nRiseA, 2);
  endtask

  task test_lvds;
    logic [1:0] r;
    do_reset(MODE_LVDS, 2'd0);
    nRiseL = 0;
    pulse(-600, 200);
    chk("lvds code", codeA, 0);
    chk("lvds flag", ofL, 1);
    pulse(1, 200);
    chk("lvds flag low", ofL, 0);
    chk("lvds rises", nRiseL, 2);
    // software stop: the next sample must leave the outputs alone
    axw(REG_CTRL, 32'h0, r);
    chk("ctrl write", r, RESP_OKAY);
    pulse(-600, 200);
    chk("run off holds", codeA, 10'h201);
    chk("run off flag", ofL, 0);
  endtask

  // stabilizer on: lock wait, uneven duty, interrupts, stop and relock
  task test_stab(input logic [1:0] f);
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(MODE_FULL, f);
    repeat (99) pulse(5, 160);
    axr(REG_SAMPLES, d, r);
    chk("unlocked output", d, 0);
    repeat (10) pulse(-7, 240);
    chk("stab code", codeA, enc(-7, f[1]).code);
    axr(REG_STATUS, d, r);
    chk("status", d[STAT_ACT_BIT:0], {3'h7, f[1], 2'h0});
    axr(REG_IRQ_STATUS, d, r);
    chk("lock event", d[IRQ_LOCK_BIT], 1);
    axw(REG_IRQ_ENABLE, 32'h1 << IRQ_LOCK_BIT, r);
    repeat (3) @(posedge clk);
    chk("irq raised", irq, 1);
    axw(REG_IRQ_CLEAR, 32'h7, r);
    repeat (3) @(posedge clk);
    chk("irq cleared", irq, 0);
    repeat (50) @(posedge clk);
    axr(REG_IRQ_STATUS, d, r);
    chk("stop event", d[IRQ_STOP_BIT], 1);
    chk("irq masked", irq, 0);
    repeat (50) pulse(9, 200);
    chk("relock hold", codeA, enc(-7, f[1]).code);
    repeat (60) pulse(9, 200);
    chk("relocked", codeA, enc(9, f[1]).code);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset, sampleClockPos, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {analogLevel, outputModeLevel, formatLevel, awaddr, araddr, wdata, wstrb} = '0;
    {n_mismatch, checks, cyc, nRiseA, nRiseL} = '0;
    do_reset(MODE_FULL, 2'd0);
    test_regs;
    test_full;
    test_demux(MODE_SIMUL);
    test_demux(MODE_INTER);
    test_lvds;
    test_stab(2'd1);
    test_stab(2'd2);
    conclude;
  end
endmodule
